//--- sadc_fifo.sv
`timescale 1ns/1ps
module sadc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];  // storage flops
  logic [PW-1:0]    wr_ptr_ff;       // next write slot
  logic [PW-1:0]    rd_ptr_ff;       // head slot
  logic [CW-1:0]    cnt_ff;          // words held
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != FULL_CNT);
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write, no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // pointers wrap at depth, which need not be a power of two
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (push && !pop) begin
      cnt_ff <= cnt_ff + 1'b1;
    end else if (pop && !push) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

endmodule

//--- sadc_host.sv
`timescale 1ns/1ps
module sadc_host #(
  parameter int ACQ = 16  // acquisition_interval in system cycles
) (
  // pacing clock
  input  wire logic clock,
  // link pins toward the device
  output logic      cs_n,
  output logic      sclk,
  // device answers watched by the host
  input  wire logic dout,
  input  wire logic dout_oe_n,
  input  wire logic converting,
  input  wire logic zero_power_track_state,
  input  wire logic frame_active
);
  // per falling edge: {oe_n, dout, converting, tracking}
  logic [3:0] obs [1:24];
  // after deselect: {oe_n, frame_active, converting, tracking}
  logic [3:0] fin;
  // converting seen while selected, before the first clock fall
  logic       armed_conv;

  // idle pins: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end

  // half a link period, 4 system cycles gives 100 ns
  task automatic half;
    repeat (4) @(negedge clock);
  endtask

  // mode 0: select with clock low, 1: clock high, 2: both fall together
  task automatic frame(input int n, input int mode);
    armed_conv = 1'b0;
    if (mode != 0) begin
      sclk = 1'b1;
      half();
    end
    if (mode == 1) begin
      cs_n = 1'b0;
      half();
      half();
      armed_conv = converting;
    end
    for (int k = 1; k <= n; k++) begin
      cs_n = 1'b0;
      sclk = 1'b0;
      half();
      obs[k] = {dout_oe_n, dout, converting, zero_power_track_state};
      sclk = 1'b1;
      half();
    end
    cs_n = 1'b1;
    half();
    half();
    fin = {dout_oe_n, frame_active, converting, zero_power_track_state};
    sclk = 1'b0;
    repeat (ACQ) @(negedge clock);
  endtask
endmodule

//--- sadc_pkg.sv
package sadc_pkg;

  // result and front-end widths
  localparam int RES_W      = 16;
  localparam int ANA_W      = 18;
  localparam int SHIFT_W    = RES_W + 1;
  localparam int FIFO_DEPTH = 16;

  // falling-edge counter width and key edge numbers
  localparam int        CNT_W    = 5;
  localparam logic [4:0] FE_NONE  = 5'h00;
  localparam logic [4:0] FE_FIRST = 5'h01;
  localparam logic [4:0] FE_LAST  = 5'h12;
  localparam logic [4:0] FE_PRE   = 5'h11;
  localparam logic [4:0] FE_MSB   = 5'h02;  // edge before the msb shifts

  // full-scale two's complement codes
  localparam logic [15:0] POS_FULL = 16'h7fff;
  localparam logic [15:0] NEG_FULL = 16'h8000;
  localparam logic signed [17:0] ANA_POS = 18'sh07fff;
  localparam logic signed [17:0] ANA_NEG = 18'sh38000;

  // pin reset levels: chip select idles high, clock low
  localparam logic [1:0] PIN_RST = 2'h2;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,  // chip select high, tracking at low power
    ST_ARM   = 4'h2,  // selected with clock high, waiting first fall
    ST_CONV  = 4'h4,  // converting and shifting out
    ST_TRACK = 4'h8   // conversion done, selected, tracking
  } sadc_state_t;

  // the two link pins carried together
  typedef struct packed {
    logic cs_n;
    logic sclk;
  } sadc_pins_t;

endpackage

//--- sadc_readout.sv
`timescale 1ns/1ps
module sadc_readout #(
  parameter int RES_W  = sadc_pkg::RES_W,
  parameter int ANA_W  = sadc_pkg::ANA_W,
  parameter int DEPTH  = sadc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // serial link pins
  input  wire logic             cs_n,
  input  wire logic             sclk,
  output logic                  dout,
  output logic                  dout_oe_n,
  // digitised differential input stream
  input  wire logic             ana_valid,
  output logic                  ana_ready,
  input  wire logic [ANA_W-1:0] ana_data,
  // status
  output logic                  converting,
  output logic                  zero_power_track_state,
  output logic                  frame_active
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  sadc_pkg::sadc_pins_t pins_in;    // raw pins
  sadc_pkg::sadc_pins_t pins_lvl;   // synchronised levels
  sadc_pkg::sadc_pins_t pins_rise;  // rising pulses
  sadc_pkg::sadc_pins_t pins_fall;  // falling pulses

  assign pins_in.cs_n = cs_n;
  assign pins_in.sclk = sclk;

  // host clock paces all
  // the link clock is only sampled; its period must span several clocks
  sadc_sync #(
    .W       (2),
    .RST_VAL (sadc_pkg::PIN_RST)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (pins_in),
    .level    (pins_lvl),
    .rise     (pins_rise),
    .fall     (pins_fall)
  );

  logic cs_fall;    // chip select asserted
  logic cs_rise;    // chip select released
  logic sclk_lvl;   // clock level after sync
  logic sclk_fall;  // clock falling edge

  assign cs_fall   = pins_fall.cs_n;
  assign cs_rise   = pins_rise.cs_n;
  assign sclk_lvl  = pins_lvl.sclk;
  assign sclk_fall = pins_fall.sclk;

  ////////////////////////////////////////////////////////////////////////
  // input clamp and sample buffer

  logic [RES_W-1:0] clamped;      // input clamped to full scale
  logic             fifo_valid;   // a fresh sample waits
  logic [RES_W-1:0] fifo_data;    // oldest waiting sample
  logic             fifo_pop;     // sample taken at select fall

  // saturate a wide signed value to the result range
  function automatic logic [RES_W-1:0] clamp_code(
    input logic signed [ANA_W-1:0] v
  );
    logic [RES_W-1:0] r;
    r = v[RES_W-1:0];
    if (v > sadc_pkg::ANA_POS) begin
      r = sadc_pkg::POS_FULL;
    end else if (v < sadc_pkg::ANA_NEG) begin
      r = sadc_pkg::NEG_FULL;
    end
    return r;
  endfunction

  assign clamped = clamp_code(ana_data);

  // the drain side pops only when a frame samples, so it really fills
  sadc_fifo #(
    .WIDTH (RES_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (ana_valid),
    .in_ready  (ana_ready),
    .in_data   (clamped),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  sadc_pkg::sadc_state_t state_ff;     // sequencer state
  sadc_pkg::sadc_state_t nxt_state;
  logic [sadc_pkg::CNT_W-1:0] cnt_ff;  // falling edges seen this frame, held at the eighteenth
  logic [sadc_pkg::CNT_W-1:0] nxt_cnt;
  logic [RES_W-1:0]   sample_ff;       // held conversion result
  logic [RES_W-1:0]   nxt_sample;
  logic               shift_edge;      // a falling edge that shifts

  // sample at select fall
  // an empty buffer repeats the last result rather than stalling
  assign fifo_pop   = cs_fall && (state_ff == sadc_pkg::ST_IDLE) &&
                      fifo_valid;
  assign nxt_sample = fifo_pop ? fifo_data : sample_ff;

  // next state and edge count
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      sadc_pkg::ST_IDLE: begin
        if (cs_fall) begin
          if (sclk_lvl) begin
            nxt_state = sadc_pkg::ST_ARM;
            nxt_cnt   = sadc_pkg::FE_NONE;
          end else begin
            nxt_state = sadc_pkg::ST_CONV;
            nxt_cnt   = sadc_pkg::FE_FIRST;
          end
        end
      end
      sadc_pkg::ST_ARM: begin
        if (cs_rise) begin
          nxt_state = sadc_pkg::ST_IDLE;
        end else if (sclk_fall) begin
          nxt_state = sadc_pkg::ST_CONV;
          nxt_cnt   = sadc_pkg::FE_FIRST;
        end
      end
      sadc_pkg::ST_CONV: begin
        if (cs_rise) begin
          nxt_state = sadc_pkg::ST_IDLE;
        end else if (sclk_fall) begin
          nxt_cnt = cnt_ff + sadc_pkg::FE_FIRST;
          if (cnt_ff == sadc_pkg::FE_PRE) begin
            nxt_state = sadc_pkg::ST_TRACK;
          end
        end
      end
      sadc_pkg::ST_TRACK: begin
        if (cs_rise) begin
          nxt_state = sadc_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = sadc_pkg::ST_IDLE;
        nxt_cnt   = sadc_pkg::FE_NONE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= sadc_pkg::ST_IDLE;
      cnt_ff   <= sadc_pkg::FE_NONE;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sample_ff <= '0;
    end else begin
      sample_ff <= nxt_sample;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial output

  logic [sadc_pkg::SHIFT_W-1:0] shift_ff;  // leading zero then result
  logic                         dout_ff;
  logic                         oe_n_ff;

  // edges two onward shift; after the eighteenth only zeros remain
  assign shift_edge = sclk_fall && !cs_rise &&
                      (((state_ff == sadc_pkg::ST_CONV) &&
                        (cnt_ff >= sadc_pkg::FE_FIRST)) ||
                       (state_ff == sadc_pkg::ST_TRACK));

  always_ff @(posedge clock) begin
    if (rst) begin
      shift_ff <= '0;
      dout_ff  <= 1'b0;
    end else if (cs_fall && (state_ff == sadc_pkg::ST_IDLE)) begin
      shift_ff <= {1'b0, nxt_sample};
      dout_ff  <= 1'b0;
    end else if (shift_edge) begin
      dout_ff  <= shift_ff[sadc_pkg::SHIFT_W-1];
      shift_ff <= {shift_ff[sadc_pkg::SHIFT_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      oe_n_ff <= 1'b1;
    end else if (cs_rise || (state_ff == sadc_pkg::ST_IDLE)) begin
      oe_n_ff <= 1'b1;
    end else if (shift_edge) begin
      oe_n_ff <= 1'b0;
    end
  end

  assign dout      = dout_ff;
  assign dout_oe_n = oe_n_ff;

  ////////////////////////////////////////////////////////////////////////
  // status

  assign zero_power_track_state = (state_ff == sadc_pkg::ST_IDLE) ||
                                  (state_ff == sadc_pkg::ST_TRACK);
  assign converting   = (state_ff == sadc_pkg::ST_CONV);
  assign frame_active = (state_ff != sadc_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // checks

  AST_OE_IDLE: assert property (
    @(posedge clock) disable iff (rst)
    (state_ff == sadc_pkg::ST_IDLE) |=> dout_oe_n)
    else $error("output driven while deselected");
  AST_ABORT: assert property (
    @(posedge clock) disable iff (rst)
    (cs_rise && frame_active) |=> (!frame_active && dout_oe_n))
    else $error("release did not abort frame");
  AST_SAMPLE: assert property (
    @(posedge clock) disable iff (rst)
    fifo_pop |=> (sample_ff == $past(fifo_data)))
    else $error("sample not captured at select fall");
  AST_LOWCLK: assert property (
    @(posedge clock) disable iff (rst)
    (cs_fall && !sclk_lvl && !frame_active) |=>
      (converting && cnt_ff == sadc_pkg::FE_FIRST))
    else $error("low-clock select did not start conversion");
  AST_HIGHCLK: assert property (
    @(posedge clock) disable iff (rst)
    (cs_fall && sclk_lvl && !frame_active) |=>
      (state_ff == sadc_pkg::ST_ARM))
    else $error("high-clock select did not arm");
  AST_ARM_FALL: assert property (
    @(posedge clock) disable iff (rst)
    (state_ff == sadc_pkg::ST_ARM && sclk_fall && !cs_rise) |=>
      (converting && cnt_ff == sadc_pkg::FE_FIRST))
    else $error("armed select missed its first falling edge");
  AST_EDGE18: assert property (
    @(posedge clock) disable iff (rst)
    (converting && cnt_ff == sadc_pkg::FE_PRE && sclk_fall && !cs_rise)
      |=> (zero_power_track_state && !converting && !dout_oe_n))
    else $error("eighteenth edge did not enter acquisition");
  AST_TRACK_HOLD: assert property (
    @(posedge clock) disable iff (rst)
    (state_ff == sadc_pkg::ST_TRACK && !cs_rise) |=>
      (state_ff == sadc_pkg::ST_TRACK))
    else $error("conversion restarted without select toggle");
  AST_MSB: assert property (
    @(posedge clock) disable iff (rst)
    (converting && cnt_ff == sadc_pkg::FE_MSB && sclk_fall && !cs_rise)
      |=> ((dout == $past(sample_ff[RES_W-1])) && !dout_oe_n))
    else $error("msb not on third falling edge");
  AST_LEAD_ZERO: assert property (
    @(posedge clock) disable iff (rst)
    (converting && cnt_ff == sadc_pkg::FE_FIRST && sclk_fall && !cs_rise)
      |=> (!dout_oe_n && !dout))
    else $error("second edge did not drive leading zero");
  AST_CLAMP: assert property (
    @(posedge clock) disable iff (rst)
    ($signed(ana_data) > sadc_pkg::ANA_POS) |-> (clamped == sadc_pkg::POS_FULL))
    else $error("positive overrange not clamped");
  AST_LOWPOWER: assert property (
    @(posedge clock) disable iff (rst)
    ($past(pins_lvl.cs_n) && pins_lvl.cs_n && !cs_fall) |->
      zero_power_track_state)
    else $error("deselected device not in low power");

  COV_FULL_FRAME: cover property (
    @(posedge clock) disable iff (rst)
    converting ##1 (state_ff == sadc_pkg::ST_TRACK));
  COV_ABORT: cover property (
    @(posedge clock) disable iff (rst)
    converting && cs_rise);
  COV_ARM: cover property (
    @(posedge clock) disable iff (rst)
    (state_ff == sadc_pkg::ST_ARM) ##1 converting);
  COV_FIFO_FULL: cover property (
    @(posedge clock) disable iff (rst)
    ana_valid && !ana_ready);

endmodule

//--- sadc_readout_tb.sv
`timescale 1ns/1ps
module sadc_readout_tb;
  // design pins
  logic        clock;
  logic        rst;
  logic        cs_n;
  logic        sclk;
  logic        dout;
  logic        dout_oe_n;
  logic        ana_valid;
  logic        ana_ready;
  logic [17:0] ana_data;
  logic        converting;
  logic        zero_power_track_state;
  logic        frame_active;
  // bookkeeping
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;
  // sixteen samples: plain, negative and out-of-range values
  logic [17:0] stim [16] = '{18'h01234, 18'h3fffb, 18'h0ffff, 18'h30000,
    18'h07fff, 18'h38000, 18'h38001, 18'h00000, 18'h3ffff, 18'h00001,
    18'h05555, 18'h3aaaa, 18'h08000, 18'h37fff, 18'h0a5a5, 18'h00f0f};

  sadc_readout i_sadc_readout (.clock(clock), .rst(rst), .cs_n(cs_n),
    .sclk(sclk), .dout(dout), .dout_oe_n(dout_oe_n), .ana_valid(ana_valid),
    .ana_ready(ana_ready), .ana_data(ana_data), .converting(converting),
    .zero_power_track_state(zero_power_track_state),
    .frame_active(frame_active));

  sadc_host i_sadc_host (.clock(clock), .cs_n(cs_n), .sclk(sclk),
    .dout(dout), .dout_oe_n(dout_oe_n), .converting(converting),
    .zero_power_track_state(zero_power_track_state),
    .frame_active(frame_active));

  // 40 MHz system clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // hang guard, well above the ~3500 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // saturating reference, worked out from the full-scale codes
  function automatic logic [15:0] sat(input logic signed [17:0] v);
    if (v > sadc_pkg::ANA_POS) return sadc_pkg::POS_FULL;
    if (v < sadc_pkg::ANA_NEG) return sadc_pkg::NEG_FULL;
    return v[15:0];
  endfunction

  // one push, held until the fifo has room
  task automatic push(input logic [17:0] v);
    ana_valid = 1'b1;
    ana_data  = v;
    for (int w = 0; w < 50 && ana_ready !== 1'b1; w++) @(negedge clock);
    @(negedge clock);
  endtask

  // one frame through the host, then every edge judged
  task automatic run_frame(input logic [15:0] exp, input int n,
                           input int mode);
    logic [3:0]  o;
    logic        bit_exp;
    i_sadc_host.frame(n, mode);
    if (mode == 1)
      check("armed conv", {15'h0, i_sadc_host.armed_conv}, 16'h0);
    for (int k = 1; k <= n; k++) begin
      o = i_sadc_host.obs[k];
      bit_exp = (k >= 3 && k <= 18) ? exp[18-k] : 1'b0;
      check("oe_n", {15'h0, o[3]}, {15'h0, k == 1});
      check("conv", {15'h0, o[1]}, {15'h0, k < 18});
      check("track", {15'h0, o[0]}, {15'h0, k >= 18});
      if (k >= 2)
        check("dout", {15'h0, o[2]}, {15'h0, bit_exp});
    end
    check("after deselect", {12'h0, i_sadc_host.fin}, 16'h9);
  endtask

  // scenario: outputs while reset is held
  task automatic t_reset;
    repeat (8) @(negedge clock);
    check("rst oe_n", {15'h0, dout_oe_n}, 16'h1);
    check("rst state", {13'h0, converting, zero_power_track_state,
          frame_active}, 16'h2);
    check("rst ready", {15'h0, ana_ready}, 16'h1);
  endtask

  // scenario: fill the buffer until it refuses, an extra word held off
  task automatic t_fill;
    for (int i = 0; i < 16; i++) push(stim[i]);
    ana_data = 18'h01111;
    repeat (4) @(negedge clock);
    check("full refuses", {15'h0, ana_ready}, 16'h0);
    ana_valid = 1'b0;
  endtask

  // scenario: drain by frames in all select modes, one short-cycled
  task automatic t_drain;
    for (int i = 0; i < 16; i++)
      run_frame(sat(stim[i]), (i == 5) ? 8 : ((i == 9) ? 18 : 21), i % 3);
    check("empty ready", {15'h0, ana_ready}, 16'h1);
  endtask

  // scenario: a word arriving mid-frame waits for the next select
  task automatic t_capture;
    fork
      run_frame(sat(stim[15]), 21, 0);
      begin
        repeat (40) @(negedge clock);
        push(18'h00abc);
        ana_valid = 1'b0;
      end
    join
    run_frame(16'h0abc, 21, 2);
  endtask

  // main sequence
  initial begin
    rst       = 1'b1;
    ana_valid = 1'b0;
    ana_data  = 18'h00000;
    t_reset();
    repeat (8) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    t_fill();
    t_drain();
    t_capture();
    complete_run();
  end
endmodule

//--- sadc_sync.sv
`timescale 1ns/1ps
module sadc_sync #(
  parameter int         W       = 2,
  parameter logic [1:0] RST_VAL = 2'h0
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // asynchronous pins
  input  wire logic [W-1:0] async_in,
  // synchronised level and edge pulses
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta_ff;  // first stage, read only by the second
  logic [W-1:0] sync_ff;  // second stage, safe to use
  logic [W-1:0] hist_ff;  // previous synchronised value

  // two-flop chain plus a history stage for edges
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= RST_VAL[W-1:0];
      sync_ff <= RST_VAL[W-1:0];
      hist_ff <= RST_VAL[W-1:0];
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      hist_ff <= sync_ff;
    end
  end

  // edges come from the second and third stages only
  assign level = sync_ff;
  assign rise  = sync_ff & ~hist_ff;
  assign fall  = ~sync_ff & hist_ff;

endmodule
